/* dpsem_ctrl.sv */
// Purpose: host controller driving one port's semaphore pins
// Assumes: device is asynchronous; read data sampled through 3 flops
// Notes: claim is write zero then read back, never read then write
// Notes: a failed claim stays pending until polled or released
//
// Overview of operation
// - a zero written requests a token and a one written returns it.
// - a polling host drops select or output enable between reads.
// - a claim writes zero first and then reads, owning only on zero.
// - after a failed claim the host polls or writes one to withdraw.
// - at start both sides write one to all eight flags.
// - the memory array select stays high during semaphore access.
`timescale 1ns/100ps
`default_nettype none
module dpsem_ctrl
    import dpsem_pkg::*;
#(
    parameter int ACCESS_CYC = DPSEM_ACCESS_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    // command side
    input wire logic cmd_valid,
    input wire dpsem_cmd_t cmd_op,
    input wire logic [DPSEM_FLAG_W-1:0] cmd_flag,
    output logic cmd_ready,
    output logic done,
    output logic owned,
    output logic init_done,
    // device pins
    output logic mem_select_n,
    output logic semaphore_select_n,
    output logic out_enable_n,
    output logic write_n,
    output logic [DPSEM_ADDR_W-1:0] addr,
    output logic [DPSEM_DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic [DPSEM_DATA_W-1:0] data_in
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_WRITE, ST_GAP, ST_READ, ST_DONE
    } dpsem_state_t;

    dpsem_state_t state_q;
    dpsem_cmd_t op_q;
    logic [DPSEM_FLAG_W-1:0] idx_q;
    logic [3:0] cnt_q;
    logic wr_val_q;
    logic read_phase_q;
    logic rd_bit_q;
    logic [DPSEM_DATA_W-1:0] s1_q, s2_q, s3_q;
    logic cnt_end;

    // write strobe lifts a cycle before select so data outlasts it
    assign cnt_end = (cnt_q == 4'(ACCESS_CYC - 1));

    // three-flop sampling of device read data
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            s1_q <= DPSEM_DATA_RST;
            s2_q <= DPSEM_DATA_RST;
            s3_q <= DPSEM_DATA_RST;
        end else if (clk_en) begin
            s1_q <= data_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // sequencer
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_IDLE;
            op_q <= DPSEM_CMD_POLL;
            idx_q <= DPSEM_IDX_RST;
            cnt_q <= DPSEM_CNT_RST;
            wr_val_q <= 1'b1;
            cmd_ready <= 1'b0;
            done <= 1'b0;
            owned <= 1'b0;
        end else if (clk_en) begin
            done <= 1'b0;
            unique case (state_q)
                ST_IDLE: begin
                    cmd_ready <= 1'b1;
                    cnt_q <= DPSEM_CNT_RST;
                    if (cmd_valid && cmd_ready) begin
                        // drop on accept so a held valid is not taken twice
                        cmd_ready <= 1'b0;
                        op_q <= cmd_op;
                        idx_q <= (cmd_op == DPSEM_CMD_INIT) ?
                            DPSEM_IDX_RST : cmd_flag;
                        // zero requests, one releases
                        wr_val_q <= (cmd_op == DPSEM_CMD_CLAIM) ? 1'b0 : 1'b1;
                        // poll only reads; claim writes before reading
                        state_q <= (cmd_op == DPSEM_CMD_POLL) ?
                            ST_READ : ST_WRITE;
                    end
                end
                ST_WRITE: begin
                    cnt_q <= cnt_q + 4'h1;
                    if (cnt_end) begin
                        cnt_q <= DPSEM_CNT_RST;
                        state_q <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    // select idle for a cycle so a later read recaptures
                    if (op_q == DPSEM_CMD_CLAIM) begin
                        state_q <= ST_READ;
                    end else if (op_q == DPSEM_CMD_INIT &&
                            idx_q != 3'(DPSEM_FLAGS - 1)) begin
                        // every flag written one at start
                        idx_q <= idx_q + 3'h1;
                        state_q <= ST_WRITE;
                    end else begin
                        state_q <= ST_DONE;
                    end
                end
                ST_READ: begin
                    cnt_q <= cnt_q + 4'h1;
                    // three flops plus one cycle for the agreement check
                    if (cnt_q == 4'(ACCESS_CYC + DPSEM_SYNC_CYC)) begin
                        cnt_q <= DPSEM_CNT_RST;
                        // owned only if the read returns zero
                        owned <= ~rd_bit_q;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    // failed claim left pending; host polls or releases
                    if (op_q == DPSEM_CMD_RELEASE) begin
                        owned <= 1'b0;
                    end
                    if (op_q == DPSEM_CMD_INIT) begin
                        owned <= 1'b0;
                    end
                    done <= 1'b1;
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // pins lag state by a cycle; this marks a read on the pins
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            read_phase_q <= 1'b0;
        end else if (clk_en) begin
            read_phase_q <= (state_q == ST_READ);
        end
    end

    // a change counts once the last two stages agree;
    // outside a read the bus value means nothing, so it is ignored
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rd_bit_q <= 1'b1;
        end else if (clk_en && read_phase_q && s2_q[0] == s3_q[0]) begin
            rd_bit_q <= s3_q[0];
        end
    end

    // sticky: set by the first finished init, cleared only by reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            init_done <= 1'b0;
        end else if (clk_en && state_q == ST_DONE &&
                op_q == DPSEM_CMD_INIT) begin
            init_done <= 1'b1;
        end
    end

    // pin strobes, all registered
    // a deselect between accesses costs a cycle but forces a fresh capture
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mem_select_n <= 1'b1;
            semaphore_select_n <= 1'b1;
            out_enable_n <= 1'b1;
            write_n <= 1'b1;
            data_oe <= 1'b0;
        end else if (clk_en) begin
            // array select held high for semaphore cycles
            mem_select_n <= 1'b1;
            semaphore_select_n <= ~(state_q == ST_WRITE ||
                state_q == ST_READ);
            write_n <= ~(state_q == ST_WRITE && !cnt_end);
            out_enable_n <= ~(state_q == ST_READ);
            data_oe <= (state_q == ST_WRITE);
        end
    end

    // pin address and write data, all registered
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            addr <= DPSEM_ADDR_RST;
            data_out <= DPSEM_DATA_RST;
        end else if (clk_en) begin
            // low address bits pick the flag, upper bits zero
            addr <= {{(DPSEM_ADDR_W-DPSEM_FLAG_W){1'b0}}, idx_q};
            // value only on bit 0, upper bits driven high
            data_out <= {{(DPSEM_DATA_W-1){1'b1}}, wr_val_q};
        end
    end
endmodule
`default_nettype wire

/* dpsem_dev.sv */
// Purpose: behavioural two-port semaphore device
// Assumes: far port writes come from the bench
// Notes: updates on clk edges, a simplification of async latches
`timescale 1ns/100ps
`default_nettype none
module dpsem_dev (
    // near port
    input wire logic clk,
    input wire logic sem_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [11:0] addr,
    input wire logic [15:0] din,
    output logic [15:0] dout,
    // far port
    input wire logic far_wr,
    input wire logic [2:0] far_idx,
    input wire logic far_d
);
    logic [7:0] rq_n, rq_f, own_n, own_f; // unknown at start
    logic rd_act = 1'b0;
    logic rd_q = 1'b0;
    always @(posedge clk) begin
        if (!sem_n && !we_n) rq_n[addr[2:0]] = din[0];
        if (far_wr) rq_f[far_idx] = far_d;
        for (int i = 0; i < 8; i++) begin
            if (own_n[i] === 1'b1 && rq_n[i] === 1'b1) own_n[i] = 1'b0;
            if (own_f[i] === 1'b1 && rq_f[i] === 1'b1) own_f[i] = 1'b0;
            // near side wins a tie here
            if (own_n[i] !== 1'b1 && own_f[i] !== 1'b1) begin
                own_n[i] = (rq_n[i] === 1'b0);
                own_f[i] = !own_n[i] && (rq_f[i] === 1'b0);
            end
        end
        if (!sem_n && !oe_n) begin
            if (!rd_act) rd_q <= !own_n[addr[2:0]];
            rd_act <= 1'b1;
        end else rd_act <= 1'b0;
    end
    // idle bus shows the inverse so a stale value cannot pass
    assign dout = (!sem_n && !oe_n && rd_act) ? {16{rd_q}} : {16{!rd_q}};
endmodule
`default_nettype wire

/* dpsem_monitor.sv */
// Purpose: pin checks for the semaphore port controller
// Assumes: default access length, one clock domain
// Notes: read length bound is loose on purpose
`timescale 1ns/100ps
`default_nettype none
module dpsem_monitor
    import dpsem_pkg::*;
#(
    parameter int ACCESS_CYC = DPSEM_ACCESS_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // device pins
    input wire logic mem_select_n,
    input wire logic semaphore_select_n,
    input wire logic out_enable_n,
    input wire logic write_n,
    input wire logic [DPSEM_ADDR_W-1:0] addr,
    input wire logic [DPSEM_DATA_W-1:0] data_out,
    input wire logic data_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    mem_idle_a: assert property (mem_select_n)
        else $error("memory select went low");
    addr_upper_a: assert property (
        !semaphore_select_n |-> addr[11:3] == 9'h0)
        else $error("upper address bits set");
    write_bits_a: assert property (
        !write_n |-> data_oe && data_out[15:1] == 15'h7fff)
        else $error("write data bad");
    write_sel_a: assert property (
        !write_n |-> !semaphore_select_n && out_enable_n)
        else $error("write without select");
    read_hold_a: assert property (
        $fell(out_enable_n) |-> (!out_enable_n && !semaphore_select_n)[*4])
        else $error("read cut short");
    read_gap_a: assert property (
        $fell(out_enable_n) |-> ##[1:12] out_enable_n)
        else $error("read never ends");
    sel_gap_a: assert property (
        $rose(write_n) |=> semaphore_select_n)
        else $error("no deselect between write and read");
    claim_read_a: assert property (
        $rose(write_n) && $past(data_out[0]) == 1'b0 |->
        ##[1:8] !out_enable_n)
        else $error("zero write not read back");
    oe_drive_a: assert property (!out_enable_n |-> !data_oe)
        else $error("driving data during read");
endmodule
bind dpsem_ctrl dpsem_monitor #(.ACCESS_CYC(ACCESS_CYC)) dpsem_monitor_i (
    .clk(clk), .reset(reset), .mem_select_n(mem_select_n),
    .semaphore_select_n(semaphore_select_n), .out_enable_n(out_enable_n),
    .write_n(write_n), .addr(addr), .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

/* dpsem_pkg.sv */
// Purpose: constants for the semaphore port controller
// Assumes: one 50 MHz clock, device pins driven from flip-flops
// Notes: times are pin phase lengths, access given in ns and rounded up to cycles
package dpsem_pkg;
    localparam int DPSEM_CLK_MHZ = 50;
    localparam int DPSEM_ACCESS_NS = 55;
    localparam int DPSEM_ACCESS_CYC =
        (DPSEM_ACCESS_NS * DPSEM_CLK_MHZ + 999) / 1000;
    localparam int DPSEM_DATA_W = 16;
    localparam int DPSEM_ADDR_W = 12;
    localparam int DPSEM_FLAG_W = 3;
    localparam int DPSEM_FLAGS = 8;
    localparam int DPSEM_SYNC_CYC = 3;
    localparam logic [3:0] DPSEM_CNT_RST = 4'h0;
    localparam logic [DPSEM_DATA_W-1:0] DPSEM_DATA_RST = 16'h0000;
    localparam logic [DPSEM_ADDR_W-1:0] DPSEM_ADDR_RST = 12'h000;
    localparam logic [DPSEM_FLAG_W-1:0] DPSEM_IDX_RST = 3'h0;
    typedef enum logic [2:0] {
        DPSEM_CMD_CLAIM,
        DPSEM_CMD_RELEASE,
        DPSEM_CMD_POLL,
        DPSEM_CMD_INIT
    } dpsem_cmd_t;
endpackage

/* test_dual_port_semaphore_flags.sv */
// Purpose: scenario bench for the semaphore port controller
// Assumes: default access length, far port driven here
// Notes: far side reads are not modelled
`timescale 1ns/100ps
`default_nettype none
module test_dual_port_semaphore_flags;
    import dpsem_pkg::*;
    logic clk, reset, cmd_valid, cmd_ready, done, owned, init_done;
    logic mem_select_n, sem_n, oe_n, we_n, data_oe, far_wr, far_d;
    logic clk_en;
    dpsem_cmd_t cmd_op;
    logic [2:0] cmd_flag, far_idx;
    logic [11:0] addr;
    logic [15:0] dout, din;
    int bad_count = 0;
    int checks = 0;
    int cyc = 0;
    dpsem_ctrl dpsem_ctrl_i (.clk(clk), .reset(reset), .clk_en(clk_en),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_flag(cmd_flag),
        .cmd_ready(cmd_ready), .done(done), .owned(owned),
        .init_done(init_done), .mem_select_n(mem_select_n),
        .semaphore_select_n(sem_n), .out_enable_n(oe_n), .write_n(we_n),
        .addr(addr), .data_out(dout), .data_oe(data_oe), .data_in(din));
    dpsem_dev dpsem_dev_i (.clk(clk), .sem_n(sem_n), .oe_n(oe_n),
        .we_n(we_n), .addr(addr), .din(dout), .dout(din), .far_wr(far_wr),
        .far_idx(far_idx), .far_d(far_d));
    task automatic run(input dpsem_cmd_t op, input logic [2:0] f);
        while (cmd_ready !== 1'b1) @(posedge clk) #1;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_flag = f;
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        while (done !== 1'b1) @(posedge clk) #1;
        @(posedge clk) #1;
    endtask
    task automatic far(input logic [2:0] i, input logic d);
        far_wr = 1'b1;
        far_idx = i;
        far_d = d;
        @(posedge clk) #1;
        far_wr = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic chk(input logic exp);
        checks++;
        if (owned !== exp) begin
            bad_count++;
            $display("[FAIL] %0t owned is %b", $time, owned);
        end
    endtask
    task automatic t_init();
        run(DPSEM_CMD_INIT, 3'h0);
        for (int i = 0; i < 8; i++) far(i[2:0], 1'b1);
        chk(1'b0);
        checks++;
        if (init_done !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t init flag low", $time);
        end
    endtask
    task automatic t_claim();
        run(DPSEM_CMD_CLAIM, 3'h7);
        chk(1'b1);
        far(3'h7, 1'b0);
        run(DPSEM_CMD_POLL, 3'h7);
        chk(1'b1);
        far(3'h7, 1'b1);
        run(DPSEM_CMD_RELEASE, 3'h7);
        chk(1'b0);
        run(DPSEM_CMD_POLL, 3'h7);
        chk(1'b0);
    endtask
    task automatic t_handover();
        far(3'h5, 1'b0);
        run(DPSEM_CMD_CLAIM, 3'h5);
        chk(1'b0);
        far(3'h5, 1'b1);
        run(DPSEM_CMD_POLL, 3'h5);
        chk(1'b1);
        run(DPSEM_CMD_RELEASE, 3'h5);
        chk(1'b0);
    endtask
    task automatic t_freeze();
        while (cmd_ready !== 1'b1) @(posedge clk) #1;
        cmd_valid = 1'b1;
        cmd_op = DPSEM_CMD_CLAIM;
        cmd_flag = 3'h3;
        @(posedge clk) #1;
        cmd_valid = 1'b0;
        clk_en = 1'b0;
        repeat (10) @(posedge clk) #1;
        checks++;
        if (sem_n !== 1'b1 || done !== 1'b0 || cmd_ready !== 1'b0) begin
            bad_count++;
            $display("[FAIL] %0t moved while frozen", $time);
        end
        clk_en = 1'b1;
        while (done !== 1'b1) @(posedge clk) #1;
        @(posedge clk) #1;
        chk(1'b1);
        run(DPSEM_CMD_RELEASE, 3'h3);
        chk(1'b0);
    endtask
    task automatic test_done();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            bad_count++;
            test_done();
        end
    end
    initial begin
        reset = 1'b1;
        cmd_valid = 1'b0;
        cmd_op = DPSEM_CMD_POLL;
        cmd_flag = 3'h0;
        far_wr = 1'b0;
        far_idx = 3'h0;
        far_d = 1'b1;
        clk_en = 1'b1;
        repeat (20) @(posedge clk);
        #1 reset = 1'b0;
        t_init();
        t_claim();
        t_handover();
        t_freeze();
        test_done();
    end
endmodule
`default_nettype wire
